// File: design/esc_pkg.sv
// Shared constants and carrier types for the external bus and system-control block.
// Assumes a single 250 MHz core clock and that every pin input is already synchronous to it.
package esc_pkg;

    // Bus widths and the area decode field.
    localparam int ESC_AW = 24; // Address lines 23 down to 0.
    localparam int ESC_DW = 16; // Data lines 15 down to 0.
    localparam int ESC_AREAS = 8; // One chip select for each area.
    localparam int ESC_AREA_LSB = 21; // Lowest address bit of the area number.
    localparam int ESC_AREA_W = 3; // Width of the area number.
    localparam int ESC_BE_HI = 1; // Byte-enable bit for data lines 15 to 8.
    localparam int ESC_BE_LO = 0; // Byte-enable bit for data lines 7 to 0.

    // Clock and reset-output stretch timing.
    localparam int ESC_CLK_PERIOD_NS = 4; // Core clock period in ns.
    localparam int ESC_RESET_OUT_N_NS = 100; // Least time the reset output stays low after reset.
    localparam int ESC_RESET_OUT_N_CW = 5; // Width of the reset-output counter.
    localparam logic [ESC_RESET_OUT_N_CW-1:0] ESC_RESET_OUT_N_CNT =
        ESC_RESET_OUT_N_CW'((ESC_RESET_OUT_N_NS + ESC_CLK_PERIOD_NS - 1) / ESC_CLK_PERIOD_NS);

    // Bus sequencer states, one-hot.
    typedef enum logic [5:0] {
        ESC_IDLE  = 6'h01, // Bus owned and quiet.
        ESC_T1    = 6'h02, // Address and chip select out, address strobe low.
        ESC_T2    = 6'h04, // Read or write strobes low; waits are inserted here.
        ESC_T3    = 6'h08, // Strobes released, answer given.
        ESC_GRANT = 6'h10, // Bus released to an external master.
        ESC_HW_STANDBY_N  = 6'h20  // Hardware standby.
    } esc_fsm_t;

    // Request from the core side.
    typedef struct packed {
        logic write; // High for a write, low for a read.
        logic [ESC_AW-1:0] addr; // Target address.
        logic [ESC_DW-1:0] wdata; // Write data.
        logic [1:0] be; // Byte enables for a write.
    } esc_req_t;

    // Answer to the core side.
    typedef struct packed {
        logic [ESC_DW-1:0] rdata; // Read data, zero after a write.
    } esc_rsp_t;

    // Complete state of the block.
    typedef struct packed {
        esc_fsm_t fsm;
        esc_req_t cur; // Access in progress.
        logic [ESC_AW-1:0] addr_bus;
        logic as_n;
        logic read_n;
        logic upper_write_n;
        logic lower_write_n;
        logic [ESC_DW-1:0] data_out;
        logic data_oe;
        logic bus_oe;
        logic bus_ack_n;
        logic cs_en;
        logic reset_out_n;
        logic [ESC_RESET_OUT_N_CW-1:0] reset_out_n_cnt;
        esc_rsp_t rsp;
        logic rsp_valid;
    } esc_state_t;

    // Value taken at reset: every strobe inactive and driven high.
    localparam esc_state_t ESC_ST_RST = '{
        fsm: ESC_IDLE,
        cur: '0,
        addr_bus: '0,
        as_n: 1'b1,
        read_n: 1'b1,
        upper_write_n: 1'b1,
        lower_write_n: 1'b1,
        data_out: '0,
        data_oe: 1'b0,
        bus_oe: 1'b1,
        bus_ack_n: 1'b1,
        cs_en: 1'b0,
        reset_out_n: 1'b0,
        reset_out_n_cnt: ESC_RESET_OUT_N_CNT,
        rsp: '0,
        rsp_valid: 1'b0
    };

endpackage

// File: design/esc_area_decode.sv
// Area decoder that turns the top address bits into eight active-low chip selects.
// Assumes the enable comes from a flip-flop so the selects change with the clock edge.
`timescale 1ns/100ps
module esc_area_decode
    import esc_pkg::*;
(
    input wire logic [ESC_AW-1:0] addr,
    input wire logic enable,
    output logic [ESC_AREAS-1:0] chip_sel_n
);

    // Area number taken from the top bits of the address.
    logic [ESC_AREA_W-1:0] area;

    assign area = addr[ESC_AREA_LSB +: ESC_AREA_W];

    // One select per area; only the addressed one goes low, and none while disabled.
    genvar gi;
    generate
        for (gi = 0; gi < ESC_AREAS; gi++) begin : g_cs
            assign chip_sel_n[gi] = !(enable && (area == ESC_AREA_W'(gi)));
        end
    endgenerate

endmodule

// File: design/esc_bus_ctrl.sv
// External bus sequencer with reset, reset-output, standby and bus-release control.
// Assumes all pin inputs are synchronous to core_clk and that a wrapper resolves the
// shared pins from the output enables.
`timescale 1ns/100ps

// Function
// - Low reset input puts block in reset.
// - Reset output tells outside devices about reset.
// - Low standby input enters hardware standby.
// - Acknowledge asserted after bus is released.
// - 24-line output address bus drives access address.
// - 16-bit data bus, driven on writes only.
// - Eight active-low area selects, one asserted.
// - Address strobe low while address valid.
// - Read strobe low during external reads.
// - Upper write low with valid upper data.
// - Lower write low with valid lower data.
// - Wait input stretches the running bus cycle.
module esc_bus_ctrl
    import esc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reset_in_n,
    output logic reset_out_n,
    input wire logic hw_standby_n,
    output logic standby_active,
    input wire logic bus_request_n,
    output logic bus_ack_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire esc_req_t core_req,
    output logic rsp_valid,
    output esc_rsp_t core_rsp,
    output logic [ESC_AW-1:0] addr_bus,
    output logic [ESC_AREAS-1:0] chip_sel_n,
    output logic addr_strobe_n,
    output logic read_n,
    output logic upper_write_n,
    output logic lower_write_n,
    output logic bus_oe,
    output logic [ESC_DW-1:0] data_out,
    output logic data_oe,
    input wire logic [ESC_DW-1:0] data_in,
    input wire logic wait_n
);

    // Registered state and its next value.
    esc_state_t st;
    esc_state_t next_st;

    // A new access is only taken on a quiet, owned bus with reset finished and no
    // external master asking; the master's request wins over a core request.
    assign req_ready = (st.fsm == ESC_IDLE) && st.bus_oe && st.reset_out_n
                       && bus_request_n && hw_standby_n && reset_in_n;

    // Next-state logic for the whole block.
    always_comb begin
        next_st = st;
        next_st.rsp_valid = 1'b0;

        // Reset output stays low for a fixed stretch after the block leaves reset.
        if (!st.reset_out_n) begin
            if (st.reset_out_n_cnt != '0) begin
                next_st.reset_out_n_cnt = st.reset_out_n_cnt - 1'b1;
            end else begin
                next_st.reset_out_n = 1'b1;
            end
        end

        unique case (st.fsm)
            // Quiet bus: start an access or hand the bus over.
            ESC_IDLE: begin
                next_st.bus_oe = 1'b1; // Take the bus back after a grant.
                if (!bus_request_n && st.bus_oe) begin
                    // Release first; acknowledge follows on the next edge.
                    next_st.fsm = ESC_GRANT;
                    next_st.bus_oe = 1'b0;
                end else if (req_valid && req_ready) begin
                    next_st.fsm = ESC_T1;
                    next_st.cur = core_req;
                    next_st.addr_bus = core_req.addr;
                    next_st.cs_en = 1'b1;
                    next_st.as_n = 1'b0;
                end
            end
            // Address phase: bring up the read or write strobes.
            ESC_T1: begin
                next_st.fsm = ESC_T2;
                if (st.cur.write) begin
                    next_st.data_out = st.cur.wdata;
                    next_st.data_oe = 1'b1;
                    next_st.upper_write_n = !st.cur.be[ESC_BE_HI];
                    next_st.lower_write_n = !st.cur.be[ESC_BE_LO];
                end else begin
                    next_st.read_n = 1'b0;
                end
            end
            // Strobe phase: hold while the wait input is low.
            ESC_T2: begin
                if (wait_n) begin
                    next_st.fsm = ESC_T3;
                    next_st.rsp.rdata = st.cur.write ? '0 : data_in;
                    next_st.read_n = 1'b1;
                    next_st.upper_write_n = 1'b1;
                    next_st.lower_write_n = 1'b1;
                    next_st.as_n = 1'b1;
                    next_st.rsp_valid = 1'b1;
                end
            end
            // Closing phase: data held one more cycle for hold time, then quiet.
            ESC_T3: begin
                next_st.fsm = ESC_IDLE;
                next_st.data_oe = 1'b0;
                next_st.cs_en = 1'b0;
            end
            // Bus released: acknowledge until the master lets go.
            ESC_GRANT: begin
                if (bus_request_n) begin
                    next_st.fsm = ESC_IDLE;
                    next_st.bus_ack_n = 1'b1;
                end else begin
                    next_st.bus_ack_n = 1'b0;
                end
            end
            // Standby: stay dark until the standby input rises.
            ESC_HW_STANDBY_N: begin
                next_st.fsm = ESC_IDLE;
            end
        endcase

        // Standby overrides everything except reset; an access in flight is dropped
        // without an answer, which the core must tolerate.
        if (!hw_standby_n) begin
            next_st = st;
            next_st.fsm = ESC_HW_STANDBY_N;
            next_st.as_n = 1'b1;
            next_st.read_n = 1'b1;
            next_st.upper_write_n = 1'b1;
            next_st.lower_write_n = 1'b1;
            next_st.cs_en = 1'b0;
            next_st.data_oe = 1'b0;
            next_st.bus_oe = 1'b0;
            next_st.bus_ack_n = 1'b1;
            next_st.rsp_valid = 1'b0;
        end

        // The reset pin wins over all, and restarts the reset-output stretch.
        if (!reset_in_n) begin
            next_st = ESC_ST_RST;
        end
    end

    // The single state register; async reset loads only the constant reset value.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= ESC_ST_RST;
        end else begin
            st <= next_st;
        end
    end

    // Chip select decode from the registered address and enable.
    esc_area_decode u_area_decode (
        .addr(st.addr_bus),
        .enable(st.cs_en),
        .chip_sel_n(chip_sel_n)
    );

    // Pin outputs straight from the state register.
    assign reset_out_n = st.reset_out_n;
    assign standby_active = (st.fsm == ESC_HW_STANDBY_N);
    assign bus_ack_n = st.bus_ack_n;
    assign addr_bus = st.addr_bus;
    assign addr_strobe_n = st.as_n;
    assign read_n = st.read_n;
    assign upper_write_n = st.upper_write_n;
    assign lower_write_n = st.lower_write_n;
    assign bus_oe = st.bus_oe;
    assign data_out = st.data_out;
    assign data_oe = st.data_oe;
    assign rsp_valid = st.rsp_valid;
    assign core_rsp = st.rsp;

endmodule

// File: tb/esc_sva.sv
// Checker for the external bus sequencer pins.
// Assumes the far side never holds wait for more than a few cycles.
`timescale 1ns/100ps
module esc_sva
    import esc_pkg::*;
(
    input wire logic core_clk, rst_n, reset_in_n, reset_out_n, hw_standby_n,
    input wire logic standby_active, bus_request_n, bus_ack_n, req_valid, req_ready,
    input wire esc_req_t core_req,
    input wire logic rsp_valid, addr_strobe_n, read_n, upper_write_n, lower_write_n,
    input wire logic [ESC_AW-1:0] addr_bus,
    input wire logic [ESC_AREAS-1:0] chip_sel_n,
    input wire logic bus_oe, data_oe, wait_n,
    input wire logic [ESC_DW-1:0] data_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // A request is taken where valid meets ready.
    wire take = req_valid && req_ready;
    wire [ESC_AREA_W-1:0] area = addr_bus[ESC_AREA_LSB +: ESC_AREA_W];
    sequence s_read;
        !addr_strobe_n && read_n ##1 !read_n;
    endsequence
    // Local copies keep the request after the core has moved on.
    property p_write;
        logic [1:0] b;
        logic [ESC_DW-1:0] d;
        logic [ESC_AW-1:0] a;
        (take && core_req.write, b = core_req.be, d = core_req.wdata, a = core_req.addr)
        |=> addr_bus == a && !addr_strobe_n ##1 data_oe && data_out == d
        && upper_write_n == !b[1] && lower_write_n == !b[0];
    endproperty
    AST_RST: assert property (!reset_in_n |=> !reset_out_n && bus_ack_n && bus_oe)
        else $error("reset input ignored");
    AST_HW_STANDBY_N: assert property (!hw_standby_n && reset_in_n |=> standby_active && !bus_oe
        && &chip_sel_n && !data_oe) else $error("standby not entered");
    AST_ACK: assert property (!bus_ack_n |-> !bus_oe)
        else $error("ack while driving bus");
    AST_GRANT: assert property ($fell(bus_oe) && !standby_active && !bus_request_n
        && reset_in_n && hw_standby_n |=> !bus_ack_n) else $error("no ack after release");
    AST_FREE: assert property (!bus_ack_n && bus_request_n && reset_in_n |=> bus_ack_n)
        else $error("ack held");
    AST_CS: assert property (!(&chip_sel_n) |-> $onehot(~chip_sel_n) && !chip_sel_n[area])
        else $error("bad chip select");
    AST_AS: assert property (!addr_strobe_n |-> bus_oe && !chip_sel_n[area])
        else $error("strobe without select");
    AST_READ: assert property (take && !core_req.write |=> s_read)
        else $error("read strobe order");
    AST_WRITE: assert property (p_write)
        else $error("write cycle wrong");
    AST_WAIT: assert property (!read_n && !wait_n |=> !read_n && !rsp_valid)
        else $error("wait not honoured");
    AST_NOWAIT: assert property (!read_n && wait_n |=> read_n && rsp_valid)
        else $error("read not finished");
    AST_ANS: assert property (take |=> !rsp_valid ##1 !rsp_valid ##[1:20] rsp_valid)
        else $error("answer timing");
    AST_IDLE: assert property (rsp_valid |-> addr_strobe_n && read_n && upper_write_n
        && lower_write_n ##1 &chip_sel_n) else $error("idle pins not high");
endmodule

bind esc_bus_ctrl esc_sva u_sva (.*);

// File: tb/esc_mem_model.sv
// Behavioural memory and peripheral on the far side of the external bus.
// Assumes the bench changes the wait count only between accesses.
`timescale 1ns/100ps
module esc_mem_model
    import esc_pkg::*;
(
    input wire logic core_clk,
    input wire logic [ESC_AW-1:0] addr_bus,
    input wire logic read_n, upper_write_n, lower_write_n, data_oe,
    input wire logic [ESC_DW-1:0] data_out,
    input wire logic [2:0] waits,
    output logic [ESC_DW-1:0] data_in,
    output logic wait_n
);
    logic [ESC_DW-1:0] mem [16] = '{default: '0}; // Aliases on the low address bits.
    logic [ESC_DW-1:0] last = '0;
    logic [2:0] wcnt = '0; // Cycles since a strobe fell.
    wire strb_n = read_n & upper_write_n & lower_write_n;
    // Released lines toggle every cycle so a stale capture cannot pass.
    assign data_in = read_n ? ~last : mem[addr_bus[3:0]];
    assign wait_n = strb_n || wcnt >= waits;
    always @(posedge core_clk) begin
        last <= data_in;
        wcnt <= strb_n ? 3'h0 : wcnt + 3'h1;
        if (!upper_write_n && data_oe) mem[addr_bus[3:0]][15:8] <= data_out[15:8];
        if (!lower_write_n && data_oe) mem[addr_bus[3:0]][7:0] <= data_out[7:0];
    end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the external bus sequencer.
// Assumes the memory model decodes the low four address bits.
`timescale 1ns/100ps
module testbench;
    import esc_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0, reset_in_n = 1'b1, hw_standby_n = 1'b1;
    logic bus_request_n = 1'b1, req_valid = 1'b0, reset_out_n, standby_active, bus_ack_n;
    logic req_ready, rsp_valid, addr_strobe_n, read_n, upper_write_n, lower_write_n;
    logic bus_oe, data_oe, wait_n;
    logic [2:0] waits = 3'h0;
    logic [ESC_AW-1:0] addr_bus;
    logic [ESC_AREAS-1:0] chip_sel_n;
    logic [ESC_DW-1:0] data_out, data_in;
    logic [ESC_DW-1:0] shadow [16] = '{default: '0}; // Expected memory contents.
    esc_req_t core_req = '0;
    esc_rsp_t core_rsp;
    int errors = 0, cmp_count = 0, seed = 32'hb6056d96;
    esc_bus_ctrl dut (.*);
    esc_mem_model u_mem (.*);
    initial forever #2 core_clk = ~core_clk;
    function automatic logic [15:0] merge(input logic [15:0] o, d, input logic [1:0] b);
        return {b[1] ? d[15:8] : o[15:8], b[0] ? d[7:0] : o[7:0]};
    endfunction
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bounded poll at the falling edge, where outputs are settled.
    task automatic await(ref logic sig, input logic lvl, input string what);
        for (int n = 0; n < 100 && sig !== lvl; n++) @(negedge core_clk);
        chk(what, 24'(lvl), 24'(sig));
    endtask
    // Counts edges from a reset release until the reset output rises.
    task automatic reset_gap();
        int n;
        for (n = 0; n < 100 && reset_out_n !== 1'b1; n++) @(negedge core_clk);
        chk("reset gap", 24'(ESC_RESET_OUT_N_CNT) + 24'h2, 24'(n));
    endtask
    task automatic access(input logic wr, input logic [23:0] a, input logic [15:0] d,
                          input logic [1:0] b);
        @(posedge core_clk);
        req_valid <= 1'b1;
        core_req <= '{write: wr, addr: a, wdata: d, be: b};
        @(negedge core_clk);
        await(req_ready, 1'b1, "ready");
        @(posedge core_clk);
        req_valid <= 1'b0;
        @(negedge core_clk);
        await(rsp_valid, 1'b1, "answer");
        if (wr) shadow[a[3:0]] = merge(shadow[a[3:0]], d, b);
        chk("rdata", wr ? 24'h0 : 24'(shadow[a[3:0]]), 24'(core_rsp.rdata));
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        reset_gap();
        access(1'b1, 24'hffffff, 16'h5aa5, 2'b11);
        access(1'b0, 24'h00000f, 16'h0000, 2'b00);
        for (int i = 0; i < 40; i++) begin
            waits <= 3'($random(seed) & 3);
            access(1'($random(seed)), 24'($random(seed)), 16'($random(seed)), 2'($random(seed)));
        end
        @(posedge core_clk);
        bus_request_n <= 1'b0;
        @(negedge core_clk);
        await(bus_ack_n, 1'b0, "ack");
        chk("granted", 24'h0, 24'({bus_oe, req_ready}));
        @(posedge core_clk);
        bus_request_n <= 1'b1;
        @(negedge core_clk);
        await(bus_oe, 1'b1, "bus back");
        @(posedge core_clk);
        hw_standby_n <= 1'b0;
        // The pin is first sampled at the next edge, so look one cycle later.
        repeat (2) @(negedge core_clk);
        chk("standby", 24'h1ff, 24'({standby_active, chip_sel_n}));
        @(posedge core_clk);
        hw_standby_n <= 1'b1;
        @(negedge core_clk);
        await(bus_oe, 1'b1, "wake");
        @(posedge core_clk);
        reset_in_n <= 1'b0;
        // The reset pin acts at the edge after it falls, so look one cycle later.
        repeat (2) @(negedge core_clk);
        chk("reset out", 24'h0, 24'(reset_out_n));
        @(posedge core_clk);
        reset_in_n <= 1'b1;
        reset_gap();
        access(1'b0, 24'h20000f, 16'h0000, 2'b00);
        print_verdict();
    end
    // About 300 cycles are needed; the 10000-cycle limit allows some thirty times that.
    initial begin
        #40000;
        errors++;
        print_verdict();
    end
endmodule
